// ### bench/sysc_config_properties.sv
`timescale 1ns/10ps
`include "sysc_params.svh"
module sysc_config_properties #(
    parameter int NUM_PORTS = 5
) (
    // clock and reset
    input logic clk,
    input logic sys_rst,
    // register bus
    input logic [7:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [3:0] avs_byteenable,
    input logic [31:0] avs_writedata,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    // fuse, debug and sequencing
    input logic fuse_erase,
    input logic prog_fuse_valid,
    input logic [15:0] prog_fuse_data,
    input logic dbg_attach,
    input logic dbg_grant,
    input logic cpu_run,
    // watched configuration
    input logic [1:0] clk_src_a,
    input logic compat_mode,
    input logic isp_enable,
    input logic low_power_enable,
    input logic [3:0] timer_prescale_field,
    input logic [1:0] wait_state_count,
    input logic latch_strobe_off,
    input logic [8*NUM_PORTS-1:0] port_mode_high_select
);
    logic [15:0] prog_q;
    logic [31:0] wd_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // part-selects of a delayed value are kept in helper flops
    always_ff @(posedge clk)
    begin
        prog_q <= prog_fuse_data;
        wd_q <= avs_writedata;
    end

    chk_stall_before_run: assert property (!cpu_run |-> avs_waitrequest)
        else $error("bus answered before start-up ended");
    chk_ack_next_cycle: assert property ((avs_read || avs_write) && cpu_run
        && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered one cycle later");
    chk_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held longer than one cycle");
    chk_reset_quiet: assert property ($fell(sys_rst) |->
        !cpu_run && avs_readdata == 32'h0)
        else $error("outputs not cleared by reset");
    chk_startup_hold: assert property ($fell(sys_rst) |-> !cpu_run [*8])
        else $error("cpu released before start-up delay");
    chk_grant_gated: assert property (!dbg_attach [*3] |-> !dbg_grant)
        else $error("debug granted without attach");
    chk_prog_loads: assert property (prog_fuse_valid && !fuse_erase |=>
        clk_src_a == prog_q[1:0] && compat_mode == prog_q[8]
        && low_power_enable == prog_q[15])
        else $error("programmer word not loaded");
    chk_erase_blank: assert property (fuse_erase |=> compat_mode
        && isp_enable && !low_power_enable && clk_src_a == 2'h0)
        else $error("erase did not give blank fuses");
    chk_aux_write: assert property (!avs_waitrequest && avs_write
        && avs_address == `SYSC_ADDR_AUX && avs_byteenable[0] |=>
        wait_state_count == wd_q[6:5] && latch_strobe_off == wd_q[0])
        else $error("aux write not applied");
    chk_tps_steady: assert property (cpu_run && $past(cpu_run)
        && $past(avs_waitrequest) |-> $stable(timer_prescale_field))
        else $error("prescale changed without a write");

    cover property (!avs_waitrequest && avs_write);
    cover property (!avs_waitrequest && avs_read);
    cover property ($rose(dbg_grant));
    cover property ($rose(cpu_run));
endmodule

bind sysc_config sysc_config_properties #(.NUM_PORTS(NUM_PORTS)) u_props (
    .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .fuse_erase,
    .prog_fuse_valid, .prog_fuse_data, .dbg_attach, .dbg_grant, .cpu_run,
    .clk_src_a, .compat_mode, .isp_enable, .low_power_enable,
    .timer_prescale_field, .wait_state_count, .latch_strobe_off,
    .port_mode_high_select
);

// ### bench/tb_top.sv
`timescale 1ns/10ps
`include "sysc_params.svh"
module tb_top;
    import sysc_pkg::*;
    localparam logic [15:0] FUSE_A = 16'h6b36;
    localparam logic [15:0] FUSE_B = 16'h9449;
    logic clk, sys_rst, avs_read, avs_write, fuse_erase, prog_fuse_valid;
    logic dbg_attach, avs_waitrequest, dbg_grant, cpu_run, osc_b_boot;
    logic compat_mode, boot_enable, isp_enable, usig_prog_enable;
    logic low_power_enable, double_speed_select, latch_strobe_off;
    logic onchip_xdata_enable, stack_in_expanded_ram, eeprom_access_enable;
    logic flash_routine_enable;
    logic [7:0] avs_address;
    logic [3:0] avs_byteenable, timer_prescale_field;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] prog_fuse_data;
    logic [1:0] clk_src_a, clk_src_b, wait_state_count;
    logic [39:0] port_mode_low_select, port_mode_high_select;
    sysc_byte_t clock_reload_divider;
    int num_errors = 0;
    int num_checks = 0;

    sysc_config #(.NUM_PORTS(5)) uut (
        .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_byteenable,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .fuse_erase,
        .prog_fuse_valid, .prog_fuse_data, .dbg_attach, .dbg_grant, .cpu_run,
        .clk_src_a, .clk_src_b, .osc_b_boot, .compat_mode, .boot_enable,
        .isp_enable, .usig_prog_enable, .low_power_enable,
        .port_mode_low_select, .port_mode_high_select, .clock_reload_divider,
        .double_speed_select, .timer_prescale_field, .latch_strobe_off,
        .onchip_xdata_enable, .wait_state_count, .stack_in_expanded_ram,
        .eeprom_access_enable, .flash_routine_enable
    );

    always #2 clk = ~clk;

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string what, input logic [39:0] seen,
        input logic [39:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until the rising edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] be, output logic [31:0] rd);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic fuse_cycle(input logic e, input logic [15:0] d);
        @(posedge clk);
        fuse_erase <= e;
        prog_fuse_valid <= !e;
        prog_fuse_data <= d;
        @(posedge clk);
        fuse_erase <= 1'b0;
        prog_fuse_valid <= 1'b0;
    endtask

    // the status read is issued at once and must wait out start-up
    task automatic do_reset;
        logic [31:0] r;
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1'b0, 8'h08, 32'h0, 4'hf, r);
        check("run status", r, 32'h1);
    endtask

    function automatic logic [7:0] soft_out(input logic [7:0] a);
        case (a)
            8'h0c: return clock_reload_divider;
            8'h10: return {7'h0, double_speed_select};
            8'h14: return {timer_prescale_field, 4'h0};
            8'h18: return {1'b0, wait_state_count, 3'h0, onchip_xdata_enable,
                latch_strobe_off};
            8'h1c: return {2'h0, flash_routine_enable, stack_in_expanded_ram,
                4'h0};
            default: return {6'h0, eeprom_access_enable, 1'b0};
        endcase
    endfunction

    task automatic test_defaults(input logic [15:0] f);
        logic [31:0] r;
        bus(1'b0, 8'h00, 32'h0, 4'hf, r);
        check("fuse word", r, {16'h0, f});
        check("fuse outs", {low_power_enable, usig_prog_enable, isp_enable,
            boot_enable, compat_mode, osc_b_boot, clk_src_b, clk_src_a},
            {f[15], f[13:12], f[10], f[8], f[4:0]});
        check("mode low", port_mode_low_select, 40'h0);
        check("mode high", port_mode_high_select,
            f[14] ? {5{8'hff}} : 40'h0);
        check("clock dflt", {clock_reload_divider, double_speed_select,
            timer_prescale_field}, {8'h0, f[5], f[8] ? 4'h5 : 4'h0});
        check("aux dflt", {latch_strobe_off, onchip_xdata_enable,
            wait_state_count, stack_in_expanded_ram, eeprom_access_enable,
            flash_routine_enable}, {1'b0, f[9], 5'h0});
    endtask

    task automatic test_debug(input logic e);
        logic [31:0] r;
        dbg_attach <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b0, 8'h08, 32'h0, 4'hf, r);
        @(negedge clk);
        check("debug grant", {dbg_grant, r[1]}, {e, e});
        @(posedge clk);
        dbg_attach <= 1'b0;
        repeat (4) @(negedge clk);
        check("debug idle", dbg_grant, 1'b0);
    endtask

    task automatic test_regs;
        logic [7:0] addr [6];
        logic [7:0] val [12];
        logic [31:0] r;
        logic [39:0] lo, hi;
        addr = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
        val = '{8'ha5, 8'h00, 8'hc0, 8'h41, 8'h10, 8'h02,
            8'h5a, 8'h01, 8'h30, 8'h22, 8'h20, 8'h00};
        // upper lanes carry junk: an 8-bit register must ignore them
        for (int k = 0; k < 12; k++)
        begin
            bus(1'b1, addr[k%6], 32'hab00_0000 | val[k], 4'h1, r);
            @(negedge clk);
            check("soft out", soft_out(addr[k%6]), val[k]);
            bus(1'b0, addr[k%6], 32'h0, 4'hf, r);
            check("soft read", r, {24'h0, val[k]});
        end
        bus(1'b1, 8'h18, 32'h0, 4'he, r);
        @(negedge clk);
        check("lane0 off", soft_out(8'h18), 8'h22);
        for (int i = 0; i < 5; i++)
        begin
            lo[8*i +: 8] = 8'(8'h11 * (i + 1));
            hi[8*i +: 8] = ~lo[8*i +: 8];
            bus(1'b1, 8'(8'h40 + 4 * i), {24'h0, lo[8*i +: 8]}, 4'h1, r);
            bus(1'b1, 8'(8'h60 + 4 * i), {24'h0, hi[8*i +: 8]}, 4'h1, r);
        end
        @(negedge clk);
        check("mode low", port_mode_low_select, lo);
        check("mode high", port_mode_high_select, hi);
        bus(1'b0, 8'h6c, 32'h0, 4'hf, r);
        check("mode read", r, {24'h0, hi[31:24]});
        bus(1'b1, 8'h30, 32'hffff_ffff, 4'hf, r);
        bus(1'b0, 8'h30, 32'h0, 4'hf, r);
        check("unmapped", r, 32'h0);
    endtask

    task automatic test_api;
        logic [31:0] r;
        bus(1'b1, 8'h04, 32'h0, 4'h3, r);
        bus(1'b0, 8'h00, 32'h0, 4'hf, r);
        check("api locked", r, {16'h0, FUSE_B});
        bus(1'b1, 8'h1c, 32'h20, 4'h1, r);
        bus(1'b1, 8'h04, 32'h0, 4'h1, r);
        bus(1'b0, 8'h00, 32'h0, 4'hf, r);
        check("api half", r, {16'h0, FUSE_B});
        bus(1'b1, 8'h04, 32'h0, 4'h3, r);
        bus(1'b0, 8'h00, 32'h0, 4'hf, r);
        check("api write", r, {16'h0, FUSE_B & ~`SYSC_FUSE_API_MASK});
        @(negedge clk);
        check("prog only", {isp_enable, low_power_enable}, 2'b10);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("ERROR watchdog expected done seen hang");
        finish_test;
    end

    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {avs_read, avs_write, fuse_erase, prog_fuse_valid, dbg_attach} = '0;
        avs_address = 8'h00;
        avs_byteenable = 4'h0;
        avs_writedata = 32'h0;
        prog_fuse_data = 16'h0;
        fuse_cycle(1'b1, 16'h0);
        @(negedge clk);
        check("erased", {compat_mode, isp_enable, low_power_enable}, 3'b110);
        fuse_cycle(1'b0, FUSE_A);
        do_reset;
        test_defaults(FUSE_A);
        test_debug(1'b1);
        test_regs;
        do_reset;
        test_defaults(FUSE_A);
        fuse_cycle(1'b1, 16'h0);
        fuse_cycle(1'b0, FUSE_B);
        do_reset;
        test_defaults(FUSE_B);
        test_debug(1'b0);
        test_api;
        finish_test;
    end
endmodule

// ### inc/sysc_fuse_if.sv
`timescale 1ns/10ps
interface sysc_fuse_if;
    sysc_pkg::sysc_fuse_s fuse_word;
    logic erase;
    logic api_we;
    logic [15:0] api_data;
    logic prog_we;
    logic [15:0] prog_data;

    modport store (
        input erase,
        input api_we,
        input api_data,
        input prog_we,
        input prog_data,
        output fuse_word
    );

    modport ctrl (
        output erase,
        output api_we,
        output api_data,
        output prog_we,
        output prog_data,
        input fuse_word
    );
endinterface

// ### inc/sysc_params.svh
`ifndef SYSC_PARAMS_SVH
`define SYSC_PARAMS_SVH

// byte addresses of the register words
`define SYSC_ADDR_FUSE_STATUS 8'h00
`define SYSC_ADDR_FUSE_API 8'h04
`define SYSC_ADDR_CTRL_STATUS 8'h08
`define SYSC_ADDR_CLK_RELOAD 8'h0c
`define SYSC_ADDR_CLK_CONTROL 8'h10
`define SYSC_ADDR_CLK_CONFIG 8'h14
`define SYSC_ADDR_AUX 8'h18
`define SYSC_ADDR_AUX_TWO 8'h1c
`define SYSC_ADDR_EECTRL 8'h20
`define SYSC_ADDR_PML_BASE 8'h40
`define SYSC_ADDR_PMH_BASE 8'h60

// field positions
`define SYSC_BIT_DOUBLE_SPEED 0
`define SYSC_PSC_LSB 4
`define SYSC_PSC_MSB 7
`define SYSC_BIT_LATCH_OFF 0
`define SYSC_BIT_XDATA_EN 1
`define SYSC_WST_LSB 5
`define SYSC_WST_MSB 6
`define SYSC_BIT_STACK 4
`define SYSC_BIT_FLASH_EN 5
`define SYSC_BIT_EEPROM_EN 1
`define SYSC_BIT_RUN 0
`define SYSC_BIT_DBG_GRANT 1

// reset, erase and api write mask values
`define SYSC_RST_CLK_RELOAD 8'h00
`define SYSC_RST_PSC_COMPAT 4'h5
`define SYSC_RST_PSC_FAST 4'h0
`define SYSC_RST_WST 2'h0
`define SYSC_PM_ALL_ONE 8'hff
`define SYSC_PM_ALL_ZERO 8'h00
`define SYSC_FUSE_ERASED 16'h1100
`define SYSC_FUSE_API_MASK 16'he7e0

// start-up delay counts in clock cycles, one per fuse code
`define SYSC_STARTUP_CNT0 11'h010
`define SYSC_STARTUP_CNT1 11'h040
`define SYSC_STARTUP_CNT2 11'h100
`define SYSC_STARTUP_CNT3 11'h400

`endif

// ### inc/sysc_pkg.sv
package sysc_pkg;

    typedef struct packed {
        logic low_power;
        logic tristate_ports;
        logic usig_enable;
        logic isp_enable;
        logic debug_enable;
        logic boot_enable;
        logic xram_default;
        logic compat_mode;
        logic [1:0] startup_sel;
        logic dbl_default;
        logic osc_b_boot;
        logic [1:0] clk_src_b;
        logic [1:0] clk_src_a;
    } sysc_fuse_s;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_LOAD = 2'b01,
        ST_WAIT = 2'b10,
        ST_RUN = 2'b11
    } sysc_state_e;

    typedef logic [7:0] sysc_byte_t;

endpackage

// ### rtl/sysc_config.sv
`timescale 1ns/10ps
`include "sysc_params.svh"
// Contract
// R1 - fuse values persist across power loss
// R2 - some fuses software-alterable, others programmer-only
// R3 - software bits return to defaults on reset
// R4 - two-bit mode per pin, ports 0-4
// R5 - pin mode default follows port-state fuse
// R6 - clock reload plus double-speed select, fuse default
// R7 - timer prescale field in clock config 7-4
// R8 - aux bit 0 stops latch strobe toggling
// R9 - aux bit 1 on-chip xdata, fuse default
// R10 - aux bits 6-5 wait state count
// R11 - aux two bit 4 stack placement
// R12 - eeprom control bit 1 eeprom access
// R13 - aux two bit 5 flash routine access
// R14 - fuse selects compatibility or fast execution
// R15 - fuse selects clock source A
// R16 - fuse selects clock source B
// R17 - fuse selects boot oscillator A or B
// R18 - fuse selects wake-up start-up delay
// R19 - debugger refused unless debug fuse set
// R20 - fuses enable bootloader, isp, signature programming
// R21 - fuse enables low power features
// R22 - fuses copied into defaults before cpu runs
module sysc_config #(
    parameter int NUM_PORTS = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // fuse maintenance, same clock domain
    input wire logic fuse_erase,
    input wire logic prog_fuse_valid,
    input wire logic [15:0] prog_fuse_data,
    // debugger attach pin
    input wire logic dbg_attach,
    output logic dbg_grant,
    // cpu sequencing
    output logic cpu_run,
    // fuse-driven configuration
    output logic [1:0] clk_src_a,
    output logic [1:0] clk_src_b,
    output logic osc_b_boot,
    output logic compat_mode,
    output logic boot_enable,
    output logic isp_enable,
    output logic usig_prog_enable,
    output logic low_power_enable,
    // software configuration
    output logic [8*NUM_PORTS-1:0] port_mode_low_select,
    output logic [8*NUM_PORTS-1:0] port_mode_high_select,
    output sysc_pkg::sysc_byte_t clock_reload_divider,
    output logic double_speed_select,
    output logic [3:0] timer_prescale_field,
    output logic latch_strobe_off,
    output logic onchip_xdata_enable,
    output logic [1:0] wait_state_count,
    output logic stack_in_expanded_ram,
    output logic eeprom_access_enable,
    output logic flash_routine_enable
);
    import sysc_pkg::*;

    sysc_fuse_if fif ();

    sysc_state_e state_q;
    sysc_state_e state_d;
    sysc_fuse_s fuse;
    logic [10:0] wait_cnt_q;
    logic ack_q;
    logic req;
    logic wr_hit;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic dbg_meta_q;
    logic dbg_sync_q;
    sysc_byte_t pml_q [NUM_PORTS];
    sysc_byte_t pmh_q [NUM_PORTS];
    sysc_byte_t reload_q;
    logic dspeed_q;
    logic [3:0] psc_q;
    logic latch_off_q;
    logic xdata_q;
    logic [1:0] wst_q;
    logic stack_q;
    logic flash_en_q;
    logic eeprom_en_q;

    function automatic sysc_byte_t merge8(input sysc_byte_t old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        merge8 = be[0] ? wd[7:0] : old;
    endfunction

    function automatic logic [10:0] startup_count(input logic [1:0] sel);
        case (sel)
            2'h0: startup_count = `SYSC_STARTUP_CNT0;
            2'h1: startup_count = `SYSC_STARTUP_CNT1;
            2'h2: startup_count = `SYSC_STARTUP_CNT2;
            default: startup_count = `SYSC_STARTUP_CNT3;
        endcase
    endfunction

    function automatic logic [3:0] psc_default(input logic compat);
        psc_default = compat ? `SYSC_RST_PSC_COMPAT : `SYSC_RST_PSC_FAST;
    endfunction

    sysc_fuse_store u_fuse (
        .clk(clk),
        .fif(fif.store)
    );

    assign fuse = fif.fuse_word;
    assign fif.erase = fuse_erase;
    assign fif.prog_we = prog_fuse_valid;
    assign fif.prog_data = prog_fuse_data;
    assign fif.api_data = avs_writedata[15:0];

    // bus write takes effect only at the edge where waitrequest is low
    assign req = (avs_read | avs_write) & (state_q == ST_RUN);
    assign wr_hit = avs_write & ack_q;
    assign avs_waitrequest = ~ack_q;
    assign avs_readdata = rdata_q;

    // api path needs both low byte lanes and the flash routine gate
    assign fif.api_we = wr_hit & (avs_address == `SYSC_ADDR_FUSE_API)
        & (&avs_byteenable[1:0]) & flash_en_q; // R2 R13

    // sequencing
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_RESET: state_d = ST_LOAD;
            ST_LOAD: state_d = ST_WAIT;
            ST_WAIT:
            begin
                if (wait_cnt_q == 11'h000)
                begin
                    state_d = ST_RUN; // R18
                end
            end
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_RESET;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q <= ST_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wait_cnt_q <= 11'h000;
        end
        else if (state_q == ST_LOAD)
        begin
            wait_cnt_q <= startup_count(fuse.startup_sel); // R18
        end
        else if (state_q == ST_WAIT && wait_cnt_q != 11'h000)
        begin
            wait_cnt_q <= wait_cnt_q - 11'h001;
        end
    end

    // cpu held until defaults are loaded and start-up delay elapsed
    assign cpu_run = (state_q == ST_RUN); // R22

    // bus acknowledge, one cycle after the request is seen
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req & ~ack_q;
        end
    end

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (avs_address == `SYSC_ADDR_FUSE_STATUS)
        begin
            rdata_d[15:0] = fuse;
        end
        else if (avs_address == `SYSC_ADDR_CTRL_STATUS)
        begin
            rdata_d[`SYSC_BIT_RUN] = cpu_run;
            rdata_d[`SYSC_BIT_DBG_GRANT] = dbg_grant;
        end
        else if (avs_address == `SYSC_ADDR_CLK_RELOAD)
        begin
            rdata_d[7:0] = reload_q;
        end
        else if (avs_address == `SYSC_ADDR_CLK_CONTROL)
        begin
            rdata_d[`SYSC_BIT_DOUBLE_SPEED] = dspeed_q;
        end
        else if (avs_address == `SYSC_ADDR_CLK_CONFIG)
        begin
            rdata_d[`SYSC_PSC_MSB:`SYSC_PSC_LSB] = psc_q;
        end
        else if (avs_address == `SYSC_ADDR_AUX)
        begin
            rdata_d[`SYSC_BIT_LATCH_OFF] = latch_off_q;
            rdata_d[`SYSC_BIT_XDATA_EN] = xdata_q;
            rdata_d[`SYSC_WST_MSB:`SYSC_WST_LSB] = wst_q;
        end
        else if (avs_address == `SYSC_ADDR_AUX_TWO)
        begin
            rdata_d[`SYSC_BIT_STACK] = stack_q;
            rdata_d[`SYSC_BIT_FLASH_EN] = flash_en_q;
        end
        else if (avs_address == `SYSC_ADDR_EECTRL)
        begin
            rdata_d[`SYSC_BIT_EEPROM_EN] = eeprom_en_q;
        end
        else
        begin
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                if (avs_address == `SYSC_ADDR_PML_BASE + 8'(4 * i))
                begin
                    rdata_d[7:0] = pml_q[i];
                end
                if (avs_address == `SYSC_ADDR_PMH_BASE + 8'(4 * i))
                begin
                    rdata_d[7:0] = pmh_q[i];
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (req & ~ack_q & avs_read)
        begin
            rdata_q <= rdata_d;
        end
    end

    // pin modes: reset clears, load applies the port-state fuse
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                pml_q[i] <= `SYSC_PM_ALL_ZERO; // R3
                pmh_q[i] <= `SYSC_PM_ALL_ZERO; // R3
            end
        end
        else if (state_q == ST_LOAD)
        begin
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                pml_q[i] <= `SYSC_PM_ALL_ZERO; // R5
                pmh_q[i] <= fuse.tristate_ports ? `SYSC_PM_ALL_ONE
                    : `SYSC_PM_ALL_ZERO; // R5
            end
        end
        else if (wr_hit)
        begin
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                if (avs_address == `SYSC_ADDR_PML_BASE + 8'(4 * i))
                begin
                    pml_q[i] <= merge8(pml_q[i], avs_writedata,
                        avs_byteenable); // R4
                end
                if (avs_address == `SYSC_ADDR_PMH_BASE + 8'(4 * i))
                begin
                    pmh_q[i] <= merge8(pmh_q[i], avs_writedata,
                        avs_byteenable); // R4
                end
            end
        end
    end

    // clock division
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            reload_q <= `SYSC_RST_CLK_RELOAD; // R3
            dspeed_q <= 1'b0; // R3
            psc_q <= `SYSC_RST_PSC_FAST; // R3
        end
        else if (state_q == ST_LOAD)
        begin
            reload_q <= `SYSC_RST_CLK_RELOAD;
            dspeed_q <= fuse.dbl_default; // R6 R22
            psc_q <= psc_default(fuse.compat_mode); // R22
        end
        else if (wr_hit && avs_byteenable[0])
        begin
            if (avs_address == `SYSC_ADDR_CLK_RELOAD)
            begin
                reload_q <= avs_writedata[7:0]; // R6
            end
            else if (avs_address == `SYSC_ADDR_CLK_CONTROL)
            begin
                dspeed_q <= avs_writedata[`SYSC_BIT_DOUBLE_SPEED]; // R6
            end
            else if (avs_address == `SYSC_ADDR_CLK_CONFIG)
            begin
                psc_q <= avs_writedata[`SYSC_PSC_MSB:`SYSC_PSC_LSB]; // R7
            end
        end
    end

    // memory access and stack placement
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            latch_off_q <= 1'b0; // R3
            xdata_q <= 1'b0; // R3
            wst_q <= `SYSC_RST_WST; // R3
            stack_q <= 1'b0; // R3
            flash_en_q <= 1'b0; // R3
            eeprom_en_q <= 1'b0; // R3
        end
        else if (state_q == ST_LOAD)
        begin
            xdata_q <= fuse.xram_default; // R9 R22
        end
        else if (wr_hit && avs_byteenable[0])
        begin
            if (avs_address == `SYSC_ADDR_AUX)
            begin
                latch_off_q <= avs_writedata[`SYSC_BIT_LATCH_OFF]; // R8
                xdata_q <= avs_writedata[`SYSC_BIT_XDATA_EN]; // R9
                wst_q <= avs_writedata[`SYSC_WST_MSB:`SYSC_WST_LSB]; // R10
            end
            else if (avs_address == `SYSC_ADDR_AUX_TWO)
            begin
                stack_q <= avs_writedata[`SYSC_BIT_STACK]; // R11
                flash_en_q <= avs_writedata[`SYSC_BIT_FLASH_EN]; // R13
            end
            else if (avs_address == `SYSC_ADDR_EECTRL)
            begin
                eeprom_en_q <= avs_writedata[`SYSC_BIT_EEPROM_EN]; // R12
            end
        end
    end

    // debugger attach pin is asynchronous to clk
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            dbg_meta_q <= 1'b0;
            dbg_sync_q <= 1'b0;
        end
        else
        begin
            dbg_meta_q <= dbg_attach;
            dbg_sync_q <= dbg_meta_q;
        end
    end

    // fuse changes reach the grant at once; no retained attach state
    assign dbg_grant = dbg_sync_q & fuse.debug_enable; // R19

    always_comb
    begin
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            port_mode_low_select[8*i +: 8] = pml_q[i];
            port_mode_high_select[8*i +: 8] = pmh_q[i];
        end
    end

    assign clk_src_a = fuse.clk_src_a; // R15
    assign clk_src_b = fuse.clk_src_b; // R16
    assign osc_b_boot = fuse.osc_b_boot; // R17
    assign compat_mode = fuse.compat_mode; // R14
    assign boot_enable = fuse.boot_enable; // R20
    assign isp_enable = fuse.isp_enable; // R20
    assign usig_prog_enable = fuse.usig_enable; // R20
    assign low_power_enable = fuse.low_power; // R21
    assign clock_reload_divider = reload_q;
    assign double_speed_select = dspeed_q;
    assign timer_prescale_field = psc_q;
    assign latch_strobe_off = latch_off_q;
    assign onchip_xdata_enable = xdata_q;
    assign wait_state_count = wst_q;
    assign stack_in_expanded_ram = stack_q;
    assign eeprom_access_enable = eeprom_en_q;
    assign flash_routine_enable = flash_en_q;
endmodule

// ### rtl/sysc_fuse_store.sv
`timescale 1ns/10ps
`include "sysc_params.svh"
module sysc_fuse_store (
    // clock
    input wire logic clk,
    // fuse access
    sysc_fuse_if.store fif
);
    import sysc_pkg::*;

    logic [15:0] fuse_q;

    // no sys_rst here: the word must survive every system reset
    always_ff @(posedge clk)
    begin
        if (fif.erase)
        begin
            fuse_q <= `SYSC_FUSE_ERASED;
        end
        else if (fif.prog_we)
        begin
            fuse_q <= fif.prog_data; // R2
        end
        else if (fif.api_we)
        begin
            fuse_q <= (fuse_q & ~`SYSC_FUSE_API_MASK)
                | (fif.api_data & `SYSC_FUSE_API_MASK); // R2
        end
    end

    assign fif.fuse_word = sysc_fuse_s'(fuse_q); // R1
endmodule
